// ---- omd_decode.sv ----
// Contract
// - Expanded mode: RAM off until software enables
// - Other modes: RAM on at $0400-$04FF
// - RAM base relocatable on 1K boundaries
// - Position writable first 64 cycles in any mode, anytime in special modes
// - Register block beats RAM; low 128 hidden
// - Base bits give address 15:10, reset $0400
// - Setup register written once when not special
// - Setup register writable anytime in special modes
// - Setup change applies at next instruction
// - Unimplemented setup bits read zero
// - RAM enable bit forced one except expanded
// - Enable bit polarity conflict resolved as enable
// - Expanded mode: boot ROM absent
// - Boot/test modes: ROM at $FC00-$FFFF
// - Single-chip: ROM also at $BC00-$BFFF
// - ROM location fixed, not relocatable
// - Boot: init serial, send break, wait
// - After first byte, count received bytes
// - End on four idle chars or 256 bytes
`timescale 1ns/1ps
module omd_decode (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [3:0]       adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // Mode and CPU side
  input  wire logic [1:0]       mode_i,
  input  wire logic             instr_start_i,
  input  wire logic [5:0]       reg_base_i,
  input  wire logic [15:0]      cpu_addr_i,
  output omd_pkg::omd_sel_t     sel_o,
  output logic                  strobe_style_select_o,
  output logic                  watchdog_disable_o,
  // Serial comms unit
  input  wire logic             rx_valid_i,
  input  wire logic [7:0]       rx_data_i,
  input  wire logic             char_tick_i,
  output logic                  serial_init_o,
  output logic                  send_break_o,
  output omd_pkg::omd_load_t    load_o,
  output logic                  boot_jump_o,
  output logic      [15:0]      jump_addr_o
);
  import omd_pkg::*;

  // ==========================================================================
  // Mode flags
  // ==========================================================================
  wire logic special_mode_flag = mode_i[1];
  wire logic mode_expanded     = (mode_i == OMD_MODE_EXPANDED);
  wire logic mode_single       = (mode_i == OMD_MODE_SINGLE);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  wire logic bus_req   = cyc_i & stb_i & ~ack_o;
  wire logic bus_wr    = bus_req & we_i & sel_i[0];
  wire logic hit_pos   = (adr_i == OMD_OFF_RAM_POS);
  wire logic hit_setup = (adr_i == OMD_OFF_SETUP);
  wire logic hit_stat  = (adr_i == OMD_OFF_STATUS);

  // ==========================================================================
  // Post-reset write window
  // ==========================================================================
  logic [6:0] win_cnt_q;
  wire logic  win_open = (win_cnt_q < OMD_INIT_WINDOW);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt_q <= 7'h00;
    end else if (win_open) begin
      win_cnt_q <= win_cnt_q + 7'h01;
    end
  end

  // ==========================================================================
  // RAM position register
  // ==========================================================================
  logic [5:0] ram_base_q;
  wire logic  pos_allowed = special_mode_flag | win_open;
  wire logic  pos_write   = bus_wr & hit_pos & pos_allowed;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ram_base_q <= OMD_RAM_BASE_RST;
    end else if (pos_write) begin
      ram_base_q <= dat_i[7:OMD_RAM_BASE_LSB];
    end
  end

  // ==========================================================================
  // System setup register: stored copy and effective copy
  // ==========================================================================
  logic [7:0] setup_q;
  logic [7:0] setup_eff_q;
  logic       setup_used_q;
  logic       setup_pend_q;
  wire logic  setup_allowed = special_mode_flag | ~setup_used_q;
  wire logic  setup_write   = bus_wr & hit_setup & setup_allowed;
  wire logic  [7:0] setup_rst = {6'h00, ~mode_expanded, 1'b0};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_q      <= setup_rst;
      setup_used_q <= 1'b0;
    end else if (setup_write) begin
      setup_q      <= dat_i[7:0] & OMD_SETUP_MASK;
      setup_used_q <= 1'b1;
    end
  end

  // Applied when the next instruction begins, never mid-instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_eff_q  <= setup_rst;
      setup_pend_q <= 1'b0;
    end else if (setup_write) begin
      setup_pend_q <= 1'b1;
    end else if (setup_pend_q && instr_start_i) begin
      setup_eff_q  <= setup_q;
      setup_pend_q <= 1'b0;
    end
  end

  // Bit set means RAM present, matching reset behaviour per mode
  wire logic ram_enabled = setup_eff_q[OMD_RAM_EN_BIT];
  assign strobe_style_select_o = setup_eff_q[OMD_STROBE_BIT];
  assign watchdog_disable_o    = setup_eff_q[OMD_WDOG_BIT];

  // ==========================================================================
  // Address decode with register block priority
  // ==========================================================================
  wire logic [5:0] page    = cpu_addr_i[15:10];
  wire logic reg_hit       = (page == reg_base_i) & (cpu_addr_i[9:7] == 3'h0);
  wire logic ram_hit       = ram_enabled & (page == ram_base_q)
                             & (cpu_addr_i[9:8] == 2'h0);
  wire logic rom_hi        = (page == OMD_ROM_HI_BASE);
  wire logic rom_hit       = ~mode_expanded
                             & (rom_hi | (mode_single & (page == OMD_ROM_ALIAS)));
  wire logic ram_sel       = ram_hit & ~reg_hit;
  wire logic rom_sel       = rom_hit & ~reg_hit & ~ram_hit;

  assign sel_o.reg_sel = reg_hit;
  assign sel_o.ram_sel = ram_sel;
  assign sel_o.rom_sel = rom_sel;
  assign sel_o.index   = reg_hit ? {3'h0, cpu_addr_i[6:0]} :
                         ram_sel ? {2'h0, cpu_addr_i[7:0]} : cpu_addr_i[9:0];

  // ==========================================================================
  // Bootloader download sequencer
  // ==========================================================================
  omd_boot_t  boot_q;
  omd_boot_t  boot_d;
  logic [8:0] byte_cnt_q;
  logic [2:0] idle_q;
  logic       boot_arm_q;
  omd_load_t  load_q;
  logic [15:0] jump_q;

  wire logic last_byte = rx_valid_i & (byte_cnt_q == OMD_RAM_BYTES - 9'h001);
  wire logic idle_end  = char_tick_i & ~rx_valid_i & (idle_q == OMD_IDLE_CHARS - 3'h1);

  always_comb begin
    boot_d = boot_q;
    unique case (boot_q)
      B_IDLE:  if (boot_arm_q) begin
        boot_d = B_INIT;
      end
      B_INIT:  boot_d = B_BREAK;
      B_BREAK: if (char_tick_i) begin
        boot_d = B_WAIT;
      end
      B_WAIT:  if (rx_valid_i) begin
        boot_d = B_COUNT;
      end
      B_COUNT: if (last_byte || idle_end) begin
        boot_d = B_DONE;
      end
      B_DONE:  boot_d = B_DONE;
      default: boot_d = B_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_q     <= B_IDLE;
      boot_arm_q <= 1'b0;
      byte_cnt_q <= 9'h000;
      idle_q     <= 3'h0;
      load_q     <= '0;
      jump_q     <= 16'h0000;
    end else begin
      boot_q     <= boot_d;
      boot_arm_q <= (mode_i == OMD_MODE_BOOT) & (boot_q == B_IDLE) & ~boot_arm_q;
      load_q.we  <= 1'b0;
      if ((boot_q == B_WAIT || boot_q == B_COUNT) && rx_valid_i) begin
        byte_cnt_q  <= byte_cnt_q + 9'h001;
        idle_q      <= 3'h0;
        load_q.we   <= 1'b1;
        load_q.addr <= OMD_BOOT_ENTRY + {7'h00, byte_cnt_q};
        load_q.data <= rx_data_i;
      end else if (boot_q == B_COUNT && char_tick_i) begin
        idle_q <= idle_q + 3'h1;
      end
      if (boot_d == B_DONE) begin
        jump_q <= OMD_BOOT_ENTRY;
      end
    end
  end

  assign serial_init_o = (boot_q == B_INIT);
  assign send_break_o  = (boot_q == B_BREAK);
  assign boot_jump_o   = (boot_q == B_DONE);
  assign jump_addr_o   = jump_q;
  assign load_o        = load_q;

  // ==========================================================================
  // Read mux and acknowledge
  // ==========================================================================
  wire logic [31:0] rd_pos   = {24'h0, ram_base_q, 2'h0};
  wire logic [31:0] rd_setup = {24'h0, setup_q};
  wire logic [31:0] rd_stat  = {9'h000, boot_q, 1'b0, byte_cnt_q, 2'h0, setup_pend_q,
                                setup_used_q, win_open, mode_i};
  wire logic [31:0] rd_data  = hit_pos ? rd_pos : hit_setup ? rd_setup :
                               hit_stat ? rd_stat : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? rd_data : 32'h0;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_pos_window_lock: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_wr && hit_pos && !special_mode_flag && !win_open) |=> $stable(ram_base_q))
    else $error("position changed after window closed");

  a_pos_write_take: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_wr && hit_pos && win_open) |=> (ram_base_q == $past(dat_i[7:2])))
    else $error("position write not stored");

  a_setup_once: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_wr && hit_setup && !special_mode_flag && setup_used_q) |=> $stable(setup_q))
    else $error("setup register written twice");

  a_setup_special: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_wr && hit_setup && special_mode_flag) |=> (setup_q == ($past(dat_i[7:0]) & 8'h26)))
    else $error("special mode write lost");

  a_setup_defer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (setup_pend_q && !instr_start_i && !setup_write) |=> $stable(setup_eff_q))
    else $error("setup applied before instruction start");

  a_setup_zero_bits: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (setup_q & 8'hD9) == 8'h00)
    else $error("unimplemented setup bit set");

  a_reg_priority: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (reg_hit |-> !sel_o.ram_sel && !sel_o.rom_sel))
    else $error("RAM selected over register block");

  a_rom_expanded: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_expanded |-> !sel_o.rom_sel)
    else $error("boot ROM decoded in expanded mode");

  a_ram_reset_state: assert property (
    @(posedge clk_i)
    (rst_i && !mode_expanded) |=> (!rst_i |-> setup_eff_q[1]))
    else $error("RAM enable not forced after reset");

  a_boot_break: assert property (
    @(posedge clk_i) disable iff (rst_i)
    serial_init_o |=> send_break_o)
    else $error("break not sent after serial init");

  a_boot_idle_end: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (boot_q == B_COUNT && idle_end) |=> boot_jump_o ##0 (jump_addr_o == 16'h0400))
    else $error("download not ended after idle");

  a_ram_reset_home: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> (ram_base_q == OMD_RAM_BASE_RST))
    else $error("RAM base not at reset position");

  a_ram_home_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!mode_expanded && !setup_used_q && (ram_base_q == OMD_RAM_BASE_RST) && !reg_hit
     && (cpu_addr_i[15:8] == {OMD_RAM_BASE_RST, 2'h0})) |-> sel_o.ram_sel)
    else $error("RAM missing at home range after reset");

  a_ram_off_expanded: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_expanded && !setup_used_q) |-> !sel_o.ram_sel)
    else $error("RAM decoded before software enabled it");

  a_ram_enable_bit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sel_o.ram_sel |-> setup_eff_q[OMD_RAM_EN_BIT])
    else $error("RAM decoded with enable bit clear");

  a_ram_low_hidden: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sel_o.ram_sel && (page == reg_base_i)) |-> cpu_addr_i[7])
    else $error("hidden RAM byte reached");

  a_pos_late_refused: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus_wr && hit_pos && !pos_allowed) |=> (ack_o && $stable(ram_base_q)))
    else $error("refused position write not acknowledged quietly");

  a_window_stays_shut: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !win_open |=> !win_open)
    else $error("write window reopened without reset");

  a_setup_apply: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (setup_pend_q && instr_start_i && !setup_write) |=> (setup_eff_q == $past(setup_q)))
    else $error("setup not applied at instruction start");

  a_rom_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (special_mode_flag && (page == OMD_ROM_HI_BASE) && !reg_hit && !ram_hit) |-> sel_o.rom_sel)
    else $error("boot ROM missing from top page");

  a_rom_alias: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_single && (page == OMD_ROM_ALIAS) && !reg_hit && !ram_hit) |-> sel_o.rom_sel)
    else $error("boot ROM alias missing in single-chip mode");

  a_rom_fixed: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sel_o.rom_sel |-> ((page == OMD_ROM_HI_BASE) || (page == OMD_ROM_ALIAS)))
    else $error("boot ROM decoded at a moved page");

  a_boot_wait_first: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ((boot_q == B_WAIT) && !rx_valid_i) |=> (boot_q == B_WAIT))
    else $error("bootloader left wait without a character");

  a_byte_count: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ((boot_q == B_COUNT) && rx_valid_i) |=> ((byte_cnt_q == ($past(byte_cnt_q) + 9'h001)) && load_o.we))
    else $error("received byte not counted");

  a_boot_full_end: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ((boot_q == B_COUNT) && last_byte) |=> (boot_jump_o && (jump_addr_o == OMD_BOOT_ENTRY)))
    else $error("download not ended after last byte");

endmodule : omd_decode

// ---- omd_pkg.sv ----
package omd_pkg;

  // ==========================================================================
  // Operating modes from the mode logic
  // ==========================================================================
  localparam logic [1:0] OMD_MODE_SINGLE   = 2'h0;
  localparam logic [1:0] OMD_MODE_EXPANDED = 2'h1;
  localparam logic [1:0] OMD_MODE_BOOT     = 2'h2;
  localparam logic [1:0] OMD_MODE_TEST     = 2'h3;

  // ==========================================================================
  // Wishbone register offsets (byte addresses)
  // ==========================================================================
  localparam logic [3:0] OMD_OFF_RAM_POS  = 4'h0;
  localparam logic [3:0] OMD_OFF_SETUP    = 4'h4;
  localparam logic [3:0] OMD_OFF_STATUS   = 4'h8;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int         OMD_RAM_BASE_LSB = 2;
  localparam int         OMD_STROBE_BIT   = 5;
  localparam int         OMD_WDOG_BIT     = 2;
  localparam int         OMD_RAM_EN_BIT   = 1;
  localparam logic [7:0] OMD_SETUP_MASK   = 8'h26;
  localparam logic [5:0] OMD_RAM_BASE_RST = 6'h01;

  // ==========================================================================
  // Memory map
  // ==========================================================================
  localparam logic [5:0] OMD_ROM_HI_BASE  = 6'h3F;
  localparam logic [5:0] OMD_ROM_ALIAS    = 6'h2F;
  localparam logic [15:0] OMD_BOOT_ENTRY  = 16'h0400;

  // ==========================================================================
  // Timing and counts
  // ==========================================================================
  localparam logic [6:0] OMD_INIT_WINDOW  = 7'h40;
  localparam logic [2:0] OMD_IDLE_CHARS   = 3'h4;
  localparam logic [8:0] OMD_RAM_BYTES    = 9'h100;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic       reg_sel;
    logic       ram_sel;
    logic       rom_sel;
    logic [9:0] index;
  } omd_sel_t;

  typedef struct packed {
    logic       we;
    logic [15:0] addr;
    logic [7:0] data;
  } omd_load_t;

  typedef enum logic [5:0] {
    B_IDLE  = 6'h01,
    B_INIT  = 6'h02,
    B_BREAK = 6'h04,
    B_WAIT  = 6'h08,
    B_COUNT = 6'h10,
    B_DONE  = 6'h20
  } omd_boot_t;

endpackage : omd_pkg

// ---- omd_cpu_model.sv ----
`timescale 1ns/1ps
module omd_cpu_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Bench control
  input  wire logic        run_i,
  input  wire logic [15:0] addr_i,
  // Toward the decoder
  output logic      [15:0] cpu_addr_o,
  output logic             instr_start_o
);
  // ==========================================================================
  // Instruction boundaries every fourth cycle while running
  // ==========================================================================
  logic [1:0] phase_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q       <= 2'h0;
      instr_start_o <= 1'b0;
    end else begin
      phase_q       <= phase_q + 2'h1;
      instr_start_o <= run_i && (phase_q == 2'h3);
    end
  end
  always_ff @(posedge clk_i) cpu_addr_o <= addr_i;
endmodule : omd_cpu_model

// ---- test_onchip_memory_map_decode.sv ----
`timescale 1ns/1ps
module test_onchip_memory_map_decode;
  import omd_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, run, rx_valid_i, char_tick_i, ack_o;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, q, r;
  logic [1:0]  mode_i, m_mode;
  logic [5:0]  rbase, m_base;
  logic [7:0]  rx_data_i, m_setup, m_eff;
  logic [15:0] req_addr, cpu_addr, jump_addr_o;
  logic        instr_start, strobe_o, wdog_o, serial_init_o, send_break_o, boot_jump_o, m_once;
  omd_sel_t    sel_o;
  omd_load_t   load_o;
  logic        load_we;
  int          errors, n_tests, cnt, tick;
  logic [1:0]  modes[5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h2};
  logic [15:0] amap[14] = '{16'h0010, 16'h0400, 16'h04FF, 16'h0500, 16'h2010, 16'h2090, 16'h20FF,
                            16'h0C10, 16'h0C90, 16'hBC00, 16'hBFFF, 16'hFBFF, 16'hFC00, 16'hFFFF};

  omd_decode omd_decode_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mode_i(mode_i),
    .instr_start_i(instr_start), .reg_base_i(rbase), .cpu_addr_i(cpu_addr), .sel_o(sel_o),
    .strobe_style_select_o(strobe_o), .watchdog_disable_o(wdog_o), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .char_tick_i(char_tick_i), .serial_init_o(serial_init_o),
    .send_break_o(send_break_o), .load_o(load_o), .boot_jump_o(boot_jump_o), .jump_addr_o(jump_addr_o));
  omd_cpu_model omd_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .addr_i(req_addr),
    .cpu_addr_o(cpu_addr), .instr_start_o(instr_start));
  assign load_we = load_o.we;

  // ==========================================================================
  // Clock, edge counter since reset release, character ticks
  // ==========================================================================
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cnt         <= rst_i ? 0 : cnt + 1;
    tick        <= tick + 1;
    char_tick_i <= (tick % 16 == 15);
  end

  task automatic test_done;
    $display("Tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic omd_sel_t exp_sel(input logic [15:0] a);
    omd_sel_t e;
    e.reg_sel = (a[15:10] == rbase) && (a[9:7] == 3'h0);
    e.ram_sel = m_eff[OMD_RAM_EN_BIT] && (a[15:10] == m_base) && (a[9:8] == 2'h0) && !e.reg_sel;
    e.rom_sel = !e.reg_sel && !e.ram_sel && (m_mode != OMD_MODE_EXPANDED) &&
                (a[15:10] == OMD_ROM_HI_BASE || (m_mode == OMD_MODE_SINGLE && a[15:10] == OMD_ROM_ALIAS));
    e.index   = e.reg_sel ? {3'h0, a[6:0]} : e.ram_sel ? {2'h0, a[7:0]} : a[9:0];
    return e;
  endfunction : exp_sel

  // ==========================================================================
  // Classic Wishbone cycle with model update at the taking edge
  // ==========================================================================
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int t;
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= s; dat_i <= d;
    @(posedge clk_i);
    t = cnt;
    k = 0;
    while (ack_o !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    check("ack", {31'h0, ack_o}, 32'h1);
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    if (w && s[0] && a == OMD_OFF_RAM_POS && (m_mode[1] || t < 64)) m_base = d[7:2];
    if (w && s[0] && a == OMD_OFF_SETUP && (m_mode[1] || !m_once)) begin
      m_setup = d[7:0] & OMD_SETUP_MASK;
      m_once  = 1'b1;
    end
  endtask : wb

  task automatic maps;
    foreach (amap[i]) begin
      req_addr <= amap[i];
      repeat (6) @(posedge clk_i);
      if (run) m_eff = m_setup;
      @(negedge clk_i);
      check("sel", {19'h0, sel_o}, {19'h0, exp_sel(amap[i])});
    end
    check("setup_out", {30'h0, strobe_o, wdog_o}, {30'h0, m_eff[OMD_STROBE_BIT], m_eff[OMD_WDOG_BIT]});
  endtask : maps

  task automatic wait_for(input string name, ref logic sig, input logic lvl, input int lim);
    int k;
    k = 0;
    while (sig !== lvl && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    check(name, {31'h0, sig}, {31'h0, lvl});
  endtask : wait_for

  task automatic boot(input int n);
    wait_for("serial_init", serial_init_o, 1'b1, 10);
    wait_for("break_on", send_break_o, 1'b1, 10);
    wait_for("break_off", send_break_o, 1'b0, 40);
    repeat (90) @(posedge clk_i);
    check("wait_first", {31'h0, boot_jump_o}, 32'h0);
    for (int i = 0; i < n; i++) begin
      r = $urandom;
      @(posedge clk_i);
      rx_valid_i <= 1'b1; rx_data_i <= r[7:0];
      @(posedge clk_i);
      rx_valid_i <= 1'b0;
      wait_for("load_we", load_we, 1'b1, 5);
      check("load", {7'h0, load_o}, {7'h0, 1'b1, 16'h0400 + 16'(i), r[7:0]});
    end
    if (n < 256) check("early_jump", {31'h0, boot_jump_o}, 32'h0);
    wait_for("jump", boot_jump_o, 1'b1, 120);
    check("jump_addr", {16'h0, jump_addr_o}, {16'h0, OMD_BOOT_ENTRY});
  endtask : boot

  initial begin
    clk_i = 0; rst_i = 1; cyc_i = 0; stb_i = 0; we_i = 0; adr_i = 0; sel_i = 0; dat_i = 0;
    mode_i = 0; rbase = 0; req_addr = 0; run = 1; rx_valid_i = 0; rx_data_i = 0; char_tick_i = 0;
    cnt = 0; tick = 0; errors = 0; n_tests = 0;
    void'($urandom(97));
    foreach (modes[j]) begin
      @(posedge clk_i);
      rst_i <= 1'b1; mode_i <= modes[j]; rbase <= 6'h00; run <= 1'b1;
      req_addr <= 16'h04FF;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      m_mode = modes[j]; m_base = OMD_RAM_BASE_RST; m_once = 1'b0;
      m_setup = (modes[j] != OMD_MODE_EXPANDED) ? 8'h02 : 8'h00;
      m_eff = m_setup;
      if (modes[j] == OMD_MODE_BOOT) boot(j == 0 ? 3 : 256);
      wb(1'b0, OMD_OFF_RAM_POS, 4'hF, 32'h0);
      check("pos_reset", q, {24'h0, OMD_RAM_BASE_RST, 2'h0});
      @(negedge clk_i);
      check("sel_reset", {19'h0, sel_o}, {19'h0, exp_sel(16'h04FF)});
      r = $urandom;
      wb(1'b1, OMD_OFF_RAM_POS, 4'hF, {24'h0, 6'h08, r[1:0]});
      rbase <= 6'h08;
      wb(1'b0, OMD_OFF_RAM_POS, 4'hF, 32'h0);
      check("pos_early", q, {24'h0, m_base, 2'h0});
      maps();
      repeat (70) @(posedge clk_i);
      wb(1'b1, OMD_OFF_RAM_POS, 4'hF, 32'h0000000C);
      wb(1'b0, OMD_OFF_RAM_POS, 4'hF, 32'h0);
      check("pos_late", q, {24'h0, m_base, 2'h0});
      run <= 1'b0;
      wb(1'b1, OMD_OFF_SETUP, 4'hF, $urandom);
      maps();
      run <= 1'b1;
      maps();
      wb(1'b1, OMD_OFF_SETUP, 4'hF, $urandom);
      wb(1'b1, OMD_OFF_SETUP, 4'hE, $urandom);
      wb(1'b0, OMD_OFF_SETUP, 4'hF, 32'h0);
      check("setup", q, {24'h0, m_setup});
      wb(1'b0, OMD_OFF_STATUS, 4'hF, 32'h0);
      check("status_mode", {30'h0, q[1:0]}, {30'h0, m_mode});
      wb(1'b0, 4'hC, 4'hF, 32'h0);
      check("unmapped", q, 32'h0);
      maps();
    end
    test_done();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    test_done();
  end
endmodule : test_onchip_memory_map_decode
